// File: design/homing_pkg.sv
// Purpose: shared constants, types and states of the homing sequencer
// Assumes: positions are signed counts of encoder feedback steps
// Notes:   speeds and time constants pass through to the motion profiler
package homing_pkg;

  localparam int POS_W = 32;                        // position width
  localparam int SPD_W = 16;                        // speed width
  localparam int TC_W  = 16;                        // time constant width
  localparam int SEL_W = 8;                         // point table selection bits

  localparam logic [3:0] METHOD_DOG_FRONT = 4'h9;   // dog front end reference
  localparam logic [3:0] METHOD_DOGLESS   = 4'hA;   // dogless index reference

  localparam logic [SEL_W-1:0] SEL_NONE = 8'h00;    // all selection bits off
  localparam logic [SPD_W-1:0] SPD_STOP = 16'h0000; // standstill speed

  // homing configuration parameters
  typedef struct packed {
    logic [3:0]              method;      // lowest digit of homing_method_param
    logic                    dirReverse;  // homing_direction_param: 1 = reverse
    logic                    dogActHigh;  // dog_polarity_param: 1 = dog active high
    logic [SPD_W-1:0]        homingSpeed; // homing_speed_param
    logic [SPD_W-1:0]        creepSpeed;  // creep_speed_param
    logic [POS_W-1:0]        homeShift;   // home_shift_param, unsigned distance
    logic signed [POS_W-1:0] homeValue;   // home_position_value_param
    logic signed [POS_W-1:0] posMin;      // lower end of position data range
    logic signed [POS_W-1:0] posMax;      // upper end of position data range
  } homing_cfg_t;

  // acceleration and deceleration time constants of point table entry 1
  typedef struct packed {
    logic [TC_W-1:0] accelTime;  // acceleration time constant
    logic [TC_W-1:0] decelTime;  // deceleration time constant
  } time_const_t;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,  // stationary
    ST_BACKOFF = 3'b001,  // leave the dog before homing
    ST_SEEK    = 3'b010,  // homing speed toward dog or index
    ST_RETURN  = 3'b011,  // reversed after stroke end, looking for dog
    ST_SHIFT   = 3'b100,  // creep to reference plus shift
    ST_AUTOPOS = 3'b101   // move to established home
  } seq_state_t;

endpackage : homing_pkg

// File: design/homing_pos_counter.sv
// Purpose: current position counter fed by encoder feedback steps
// Assumes: at most one step per clock
// Notes:   a load overrides a step in the same cycle
`timescale 1ns/1ns
module homing_pos_counter
  import homing_pkg::*;
(
  input  wire logic                    ref_clk,   // system clock
  input  wire logic                    arst_n,    // async reset, active low
  input  wire logic                    stepPulse, // one feedback step
  input  wire logic                    stepFwd,   // step direction, 1 = forward
  input  wire logic                    loadEn,    // load new position
  input  wire logic signed [POS_W-1:0] loadValue, // position to load
  output      logic signed [POS_W-1:0] pos_q      // current position
);

  // count steps, take a load when asked
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= '0;
    end else if (loadEn) begin
      pos_q <= loadValue;
    end else if (stepPulse) begin
      pos_q <= stepFwd ? pos_q + POS_W'(1) : pos_q - POS_W'(1);
    end
  end

endmodule // homing_pos_counter

// File: design/servo_homing_sequencer.sv
// Purpose: homing sequencer: dog front end, dogless index, auto return, auto positioning
// Assumes: all inputs synchronous to ref_clk; host keeps its own sequencing
// Notes:   outputs a speed and direction command to an external profiler
`timescale 1ns/1ns

// Functional notes
// - method code 9 selects dog front end
// - home at dog leading edge
// - method code A selects dogless index
// - home at first index after start
// - homing speed until dog, then creep
// - final home offset by shift distance
// - use entry 1 time constants
// - load current position with home value
// - direction and dog polarity from parameters
// - start on dog: back off first
// - beyond dog: reverse at stroke end
// - no dog found: stop, raise alarm
// - software limit off during auto return
// - reverse start moves to established home
// - refuse auto positioning outside data range
module servo_homing_sequencer
  import homing_pkg::*;
(
  input  wire logic                    ref_clk,                 // 50 MHz clock
  input  wire logic                    arst_n,                  // async reset, active low
  input  wire logic                    auto_manual_select,      // on = manual homing family
  input  wire logic [SEL_W-1:0]        tableSelect,             // low and high selection bits
  input  wire logic                    pos_speed_source_select, // remote register source
  input  wire logic                    homingStart,             // homing start bit
  input  wire logic                    reverse_rotation_start,  // auto positioning start
  input  wire homing_cfg_t             cfg,                     // homing parameters
  input  wire time_const_t             entry1Tc,                // point table entry 1
  input  wire logic                    dogIn,                   // proximity dog pin
  input  wire logic                    forward_stroke_end,      // high = forward end reached
  input  wire logic                    reverse_stroke_end,      // high = reverse end reached
  input  wire logic                    indexPulse,              // encoder index pulse
  input  wire logic                    stepPulse,               // encoder feedback step
  input  wire logic                    stepFwd,                 // feedback step direction
  output      logic [SPD_W-1:0]        speedCmd_q,              // commanded speed
  output      logic                    dirFwd_q,                // commanded direction
  output      time_const_t             tcCmd_q,                 // time constants in use
  output      logic                    homeValid_q,             // home established
  output      logic                    homeDone_q,              // completion pulse
  output      logic                    homing_incomplete_alarm, // dog not found
  output      logic                    softLimitEn_q,           // software limit active
  output      logic                    posSourceRemote_q,       // remote source in use
  output      logic signed [POS_W-1:0] pos_q                    // current position
);

  seq_state_t              state_q;     // sequencer state
  logic                    dogPrev_q;   // dog level one cycle ago
  logic                    startPrev_q; // start bit one cycle ago
  logic                    revPrev_q;   // reverse start one cycle ago
  logic                    seenDog_q;   // dog met while returning
  logic                    autoRet_q;   // automatic return in progress
  logic signed [POS_W-1:0] target_q;    // position to reach
  logic                    loadEn;      // load home value this cycle
  logic                    dogAct;      // dog active after polarity
  logic                    dogRise;     // dog leading edge
  logic                    manualMode;  // manual homing mode selected
  logic                    startEdge;   // homing start request
  logic                    revEdge;     // auto positioning request
  logic                    homeFwd;     // homing direction is forward
  logic                    endAhead;    // stroke end in homing direction
  logic                    endBehind;   // stroke end opposite homing direction
  logic                    reached;     // target reached or crossed
  logic                    inRange;     // position inside data range
  logic signed [POS_W-1:0] shiftTarget; // reference plus shift
  logic signed [POS_W-1:0] curPos;      // counter output

  assign dogAct     = (dogIn == cfg.dogActHigh);
  assign homeFwd    = !cfg.dirReverse;
  assign dogRise    = dogAct && !dogPrev_q;
  assign endAhead   = homeFwd ? forward_stroke_end : reverse_stroke_end;
  assign endBehind  = homeFwd ? reverse_stroke_end : forward_stroke_end;
  assign manualMode = auto_manual_select && (tableSelect == SEL_NONE);
  assign startEdge  = homingStart && !startPrev_q && manualMode;
  assign revEdge    = reverse_rotation_start && !revPrev_q && manualMode;
  assign inRange    = (curPos >= cfg.posMin) && (curPos <= cfg.posMax);
  assign shiftTarget = homeFwd ? curPos + $signed(cfg.homeShift)
                               : curPos - $signed(cfg.homeShift);
  assign reached    = dirFwd_q ? (curPos >= target_q) : (curPos <= target_q);
  assign loadEn     = ((state_q == ST_SHIFT) && reached);

  // position counter
  homing_pos_counter u_pos (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .stepPulse (stepPulse),
    .stepFwd   (stepFwd),
    .loadEn    (loadEn),
    .loadValue (cfg.homeValue),
    .pos_q     (curPos)
  );
  assign pos_q = curPos;

  // edge history of the request bits and dog
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dogPrev_q   <= 1'b0;
      startPrev_q <= 1'b0;
      revPrev_q   <= 1'b0;
    end else begin
      dogPrev_q   <= dogAct;
      startPrev_q <= homingStart;
      revPrev_q   <= reverse_rotation_start;
    end
  end

  // sequencer: state, command and target
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_IDLE;
      speedCmd_q <= SPD_STOP;
      dirFwd_q   <= 1'b1;
      target_q   <= '0;
      seenDog_q  <= 1'b0;
      autoRet_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          speedCmd_q <= SPD_STOP;
          seenDog_q  <= 1'b0;
          autoRet_q  <= 1'b0;
          if (startEdge && cfg.method == METHOD_DOG_FRONT && dogAct) begin
            // on the dog, back off first
            state_q    <= ST_BACKOFF;
            autoRet_q  <= 1'b1;
            dirFwd_q   <= !homeFwd;
            speedCmd_q <= cfg.homingSpeed;
          end else if (startEdge && (cfg.method == METHOD_DOG_FRONT ||
                                     cfg.method == METHOD_DOGLESS)) begin
            state_q    <= ST_SEEK;
            dirFwd_q   <= homeFwd;
            speedCmd_q <= cfg.homingSpeed;
          end else if (revEdge && homeValid_q && inRange) begin
            state_q    <= ST_AUTOPOS;
            target_q   <= cfg.homeValue;
            dirFwd_q   <= (cfg.homeValue >= curPos);
            speedCmd_q <= cfg.homingSpeed;
          end
        end
        ST_BACKOFF: begin
          // leave the dog, then seek normally
          if (!dogAct) begin
            state_q    <= ST_SEEK;
            dirFwd_q   <= homeFwd;
            speedCmd_q <= cfg.homingSpeed;
          end
        end
        ST_SEEK: begin
          if (cfg.method == METHOD_DOG_FRONT && dogRise) begin
            state_q    <= ST_SHIFT;
            target_q   <= shiftTarget;
            speedCmd_q <= cfg.creepSpeed;
          end else if (cfg.method == METHOD_DOGLESS && indexPulse) begin
            state_q    <= ST_SHIFT;
            target_q   <= shiftTarget;
            speedCmd_q <= cfg.creepSpeed;
          end else if (endAhead && cfg.method == METHOD_DOG_FRONT) begin
            state_q   <= ST_RETURN;
            autoRet_q <= 1'b1;
            dirFwd_q  <= !homeFwd;
          end else if (endAhead) begin
            // dogless run into the end: give up
            state_q    <= ST_IDLE;
            speedCmd_q <= SPD_STOP;
          end
        end
        ST_RETURN: begin
          if (dogAct) begin
            seenDog_q <= 1'b1;
          end
          if (seenDog_q && !dogAct) begin
            state_q    <= ST_SEEK;
            autoRet_q  <= 1'b0;
            dirFwd_q   <= homeFwd;
            speedCmd_q <= cfg.homingSpeed;
          end else if (endBehind && !seenDog_q) begin
            // stop on the far stroke end
            state_q    <= ST_IDLE;
            speedCmd_q <= SPD_STOP;
          end
        end
        ST_SHIFT, ST_AUTOPOS: begin
          // stop once the target is met
          if (reached) begin
            state_q    <= ST_IDLE;
            speedCmd_q <= SPD_STOP;
          end
        end
        default: begin
          state_q    <= ST_IDLE;
          speedCmd_q <= SPD_STOP;
        end
      endcase
    end
  end

  // home status, completion pulse and alarm
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      homeValid_q             <= 1'b0;
      homeDone_q              <= 1'b0;
      homing_incomplete_alarm <= 1'b0;
    end else begin
      homeDone_q <= loadEn;
      if (loadEn) begin
        homeValid_q <= 1'b1;
      end
      if (state_q == ST_RETURN && endBehind && !seenDog_q && !dogAct) begin
        homing_incomplete_alarm <= 1'b1;
      end else if (startEdge) begin
        homing_incomplete_alarm <= 1'b0;
      end
    end
  end

  // time constants, limit enable and source echo
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tcCmd_q           <= '0;
      softLimitEn_q     <= 1'b1;
      posSourceRemote_q <= 1'b0;
    end else begin
      tcCmd_q           <= entry1Tc;
      softLimitEn_q     <= !(autoRet_q || state_q == ST_BACKOFF || state_q == ST_RETURN);
      posSourceRemote_q <= pos_speed_source_select;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  dog_mode_a: assert property (
    (state_q == ST_IDLE && startEdge && cfg.method == METHOD_DOG_FRONT && !dogAct)
      |=> state_q == ST_SEEK && speedCmd_q == cfg.homingSpeed)
    else $error("dog method start did not seek");
  dog_edge_a: assert property (
    (state_q == ST_SEEK && cfg.method == METHOD_DOG_FRONT && dogRise)
      |=> state_q == ST_SHIFT && speedCmd_q == cfg.creepSpeed)
    else $error("dog edge did not start creep");
  index_ref_a: assert property (
    (state_q == ST_SEEK && cfg.method == METHOD_DOGLESS && indexPulse)
      |=> state_q == ST_SHIFT && target_q == $past(shiftTarget))
    else $error("index pulse not taken as reference");
  home_load_a: assert property (
    (state_q == ST_SHIFT && reached) |=> pos_q == $past(cfg.homeValue) && homeValid_q
      && homeDone_q ##1 !homeDone_q)
    else $error("home value not loaded on completion");
  tc_entry1_a: assert property (
    speedCmd_q != SPD_STOP |-> tcCmd_q == $past(entry1Tc))
    else $error("time constants not from entry 1");
  backoff_dir_a: assert property (
    (state_q == ST_BACKOFF) |-> dirFwd_q == !homeFwd ##1 (state_q != ST_IDLE))
    else $error("back off wrong direction");
  return_rev_a: assert property (
    (state_q == ST_SEEK && cfg.method == METHOD_DOG_FRONT && endAhead && !dogRise)
      |=> state_q == ST_RETURN && dirFwd_q == !homeFwd)
    else $error("no reversal at stroke end");
  alarm_stop_a: assert property (
    (state_q == ST_RETURN && endBehind && !seenDog_q && !dogAct)
      |=> homing_incomplete_alarm && speedCmd_q == SPD_STOP)
    else $error("missing dog did not stop with alarm");
  limit_off_a: assert property (
    (state_q == ST_RETURN) |=> !softLimitEn_q)
    else $error("software limit active during return");
  no_home_a: assert property (
    (state_q == ST_IDLE && !homeValid_q && !startEdge) |=> state_q == ST_IDLE)
    else $error("moved without established home");
  range_refuse_a: assert property (
    (state_q == ST_IDLE && revEdge && !inRange && !startEdge) |=> state_q == ST_IDLE)
    else $error("auto positioning from outside range");

  dog_home_c:   cover property (state_q == ST_SHIFT ##[1:1000] homeDone_q);
  autopos_c:    cover property (state_q == ST_AUTOPOS ##[1:1000] state_q == ST_IDLE);
  return_c:     cover property (state_q == ST_RETURN ##[1:1000] state_q == ST_SEEK);
  alarm_c:      cover property ($rose(homing_incomplete_alarm));

endmodule // servo_homing_sequencer

// File: bench/axis_host_model.sv
// Purpose: axis stand-in: feedback steps, dog, index pulse and stroke end switches
// Assumes: one feedback step per clock while a nonzero speed is commanded
// Notes:   pins change on the falling edge; place() moves the axis between runs
`timescale 1ns/1ns
module axis_host_model
  import homing_pkg::*;
#(
  parameter int DOG_LO  = 40,   // dog leading edge position
  parameter int DOG_HI  = 60,   // dog far edge position
  parameter int FWD_END = 100,  // forward stroke end
  parameter int REV_END = -100, // reverse stroke end
  parameter int IDX_PER = 16    // steps between index pulses
) (
  input  wire logic             ref_clk,    // system clock
  input  wire logic [SPD_W-1:0] speedCmd,   // commanded speed
  input  wire logic             dirFwd,     // commanded direction
  input  wire logic             dogAct,     // active level of the dog pin
  input  wire logic             dogEn,      // low hides the dog
  output      logic             dogIn,      // dog pin
  output      logic             fwdEnd,     // forward end switch
  output      logic             revEnd,     // reverse end switch
  output      logic             indexPulse, // index pulse
  output      logic             stepPulse,  // feedback step
  output      logic             stepFwd     // step direction
);
  int ppos = 5;  // true axis position

  // teleport the axis while it stands still
  task automatic place(input int p);
    ppos = p;
  endtask

  // one step per cycle, then pins for the new place
  // place updates late so bench readers at this edge see the old place
  always @(negedge ref_clk) begin
    int nxt;
    nxt = ppos;
    if (speedCmd !== SPD_STOP) begin
      nxt = dirFwd ? ppos + 1 : ppos - 1;
    end
    ppos       <= nxt;
    stepPulse  <= (speedCmd !== SPD_STOP);
    stepFwd    <= dirFwd;
    dogIn      <= (dogEn && nxt >= DOG_LO && nxt <= DOG_HI) ? dogAct : ~dogAct;
    fwdEnd     <= (nxt >= FWD_END);
    revEnd     <= (nxt <= REV_END);
    indexPulse <= (nxt % IDX_PER == 0);
  end

  // quiet pins before the first falling edge
  initial begin
    {dogIn, fwdEnd, revEnd, indexPulse, stepPulse, stepFwd} = 6'h00;
  end
endmodule // axis_host_model

// File: bench/tb.sv
// Purpose: self-checking bench for the homing sequencer
// Assumes: axis model gives one step per cycle; dog spans 40 to 60
// Notes:   end positions may differ from the ideal by a few steps of lag
`timescale 1ns/1ns
module tb
  import homing_pkg::*;
  ;
  logic                    ref_clk, arst_n, autoSel, srcSel, homingStart, revStart;
  logic                    dogEn, dogIn, fwdEnd, revEnd, indexPulse, stepPulse, stepFwd;
  logic [SEL_W-1:0]        tableSelect;   // selection bits
  homing_cfg_t             cfg;           // homing parameters
  time_const_t             entry1Tc;      // entry 1 time constants
  logic [SPD_W-1:0]        speedCmd_q;    // commanded speed
  logic                    dirFwd_q, homeValid_q, homeDone_q, alarm, softLimitEn_q, posSrc_q;
  time_const_t             tcCmd_q;       // time constants in use
  logic signed [POS_W-1:0] pos_q;         // design position
  logic [SPD_W:0]          capVal;        // direction and speed seen at a place
  int                      failCount, testsRun, cyc, p0;
  int                      expQ[$];       // ideal end positions

  servo_homing_sequencer dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .auto_manual_select(autoSel), .tableSelect(tableSelect),
    .pos_speed_source_select(srcSel), .homingStart(homingStart),
    .reverse_rotation_start(revStart), .cfg(cfg), .entry1Tc(entry1Tc), .dogIn(dogIn),
    .forward_stroke_end(fwdEnd), .reverse_stroke_end(revEnd), .indexPulse(indexPulse),
    .stepPulse(stepPulse), .stepFwd(stepFwd), .speedCmd_q(speedCmd_q), .dirFwd_q(dirFwd_q),
    .tcCmd_q(tcCmd_q), .homeValid_q(homeValid_q), .homeDone_q(homeDone_q),
    .homing_incomplete_alarm(alarm), .softLimitEn_q(softLimitEn_q),
    .posSourceRemote_q(posSrc_q), .pos_q(pos_q));

  axis_host_model plant (.ref_clk(ref_clk), .speedCmd(speedCmd_q), .dirFwd(dirFwd_q),
    .dogAct(cfg.dogActHigh), .dogEn(dogEn), .dogIn(dogIn), .fwdEnd(fwdEnd),
    .revEnd(revEnd), .indexPulse(indexPulse), .stepPulse(stepPulse), .stepFwd(stepFwd));

  // free running clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failCount++;
      tallyAndFinish();
    end
  end

  task automatic tallyAndFinish();
    if (failCount == 0 && testsRun > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // axis ended near the ideal place
  function automatic logic near(input int got, input int ideal);
    return (got - ideal) inside {[-2:3]};
  endfunction

  // place the axis, then raise the start bit for two cycles
  task automatic startHome(input logic [3:0] m, input logic r, input int p);
    @(posedge ref_clk);
    plant.place(p);
    @(negedge ref_clk);
    cfg.method     = m;
    cfg.dirReverse = r;
    homingStart    = 1'b1;
    cycles(2);
    homingStart    = 1'b0;
  endtask

  // wait for completion, alarm or (optionally) standstill
  task automatic waitEnd(input int capAt, input logic stopOk);
    int n;
    n = 0;
    capVal = '0;
    while (homeDone_q !== 1'b1 && alarm !== 1'b1 && n < 3000 &&
           !(stopOk && speedCmd_q === SPD_STOP)) begin
      @(negedge ref_clk);
      // speed and direction that move the axis off capAt
      if (plant.ppos == capAt) capVal = {dirFwd_q, speedCmd_q};
      n++;
    end
    // no end seen in time: count it and close the run
    if (n >= 3000) begin
      failCount++;
      tallyAndFinish();
    end
  endtask

  // completion against the model's queued end place
  task automatic finishHome(input int capAt);
    waitEnd(capAt, 1'b0);
    chk(near(plant.ppos, expQ.pop_front()), 1'b1);
    chk(pos_q, cfg.homeValue);
    chk(homeValid_q, 1'b1);
    chk(homeDone_q, 1'b1);
    cycles(1);
    chk(homeDone_q, 1'b0);
  endtask

  initial begin
    void'($urandom(32'h4C12BD47));
    {arst_n, homingStart, revStart, srcSel} = 4'h0;
    dogEn            = 1'b1;
    // host: manual mode, selection bits cleared ahead of any start
    autoSel          = 1'b1;
    tableSelect      = SEL_NONE;
    cfg              = '0;
    cfg.dogActHigh   = 1'b1;
    cfg.homingSpeed  = 16'h0100 + 16'($urandom_range(255));
    cfg.creepSpeed   = 16'h0010 + 16'($urandom_range(15));
    cfg.homeShift    = 32'($urandom_range(1, 6));
    cfg.homeValue    = 32'($urandom_range(400)) - 32'h0000_00C8;
    cfg.posMin       = -32'sh0000_03E8;
    cfg.posMax       = 32'sh0000_03E8;
    entry1Tc         = time_const_t'($urandom);
    cycles(2);
    arst_n = 1'b1;
    cycles(3);
    chk({speedCmd_q, dirFwd_q, softLimitEn_q, homeValid_q}, {SPD_STOP, 3'h6});
    srcSel = 1'b1;
    cycles(2);
    chk(posSrc_q, 1'b1);
    // no home yet: auto positioning ignored
    revStart = 1'b1;
    cycles(3);
    chk(speedCmd_q, SPD_STOP);
    revStart = 1'b0;
    // selection bits set or unknown method: start ignored
    for (int i = 0; i < 4; i++) begin
      tableSelect = (i < 2) ? 8'($urandom_range(1, 255)) : SEL_NONE;
      startHome((i < 2) ? METHOD_DOGLESS : 4'($urandom_range(8)), 1'b0, 5);
      chk(speedCmd_q, SPD_STOP);
    end
    tableSelect = SEL_NONE;
    // dogless forward then reverse; first index at 16 or 0
    for (int r = 0; r < 2; r++) begin
      expQ.push_back(r ? -cfg.homeShift : 16 + cfg.homeShift);
      startHome(METHOD_DOGLESS, r[0], 5);
      chk({dirFwd_q, speedCmd_q}, {~r[0], cfg.homingSpeed});
      chk(tcCmd_q, entry1Tc);
      finishHome(-999);
    end
    // manual homing done before auto positioning
    // auto positioning to a moved home
    p0 = plant.ppos;
    cfg.homeValue = pos_q + 20;
    revStart = 1'b1;
    cycles(2);
    chk({dirFwd_q, speedCmd_q}, {1'b1, cfg.homingSpeed});
    revStart = 1'b0;
    waitEnd(-999, 1'b1);
    chk(near(plant.ppos, p0 + 20), 1'b1);
    // outside the data range: refused
    cfg.posMax    = pos_q - 1;
    cfg.homeValue = pos_q - 30;
    revStart = 1'b1;
    cycles(3);
    chk(speedCmd_q, SPD_STOP);
    revStart = 1'b0;
    cfg.posMax = 32'sh0000_03E8;
    // dog front end, both dog polarities, creep seen leaving 40
    for (int pol = 0; pol < 2; pol++) begin
      cfg.dogActHigh = pol[0];
      entry1Tc       = time_const_t'($urandom);
      expQ.push_back(40 + cfg.homeShift);
      startHome(METHOD_DOG_FRONT, 1'b0, 5);
      chk({dirFwd_q, speedCmd_q}, {1'b1, cfg.homingSpeed});
      chk(tcCmd_q, entry1Tc);
      finishHome(40);
      chk(capVal, {1'b1, cfg.creepSpeed});
    end
    // start on the dog: back off first
    expQ.push_back(40 + cfg.homeShift);
    startHome(METHOD_DOG_FRONT, 1'b0, 50);
    cycles(1);
    chk({dirFwd_q, softLimitEn_q}, 2'h0);
    finishHome(-999);
    // beyond the dog: reverse at the stroke end, seen returning at 80
    expQ.push_back(40 + cfg.homeShift);
    startHome(METHOD_DOG_FRONT, 1'b0, 70);
    finishHome(80);
    chk(capVal, {1'b0, cfg.homingSpeed});
    // dog never found: stop on the far end with the alarm
    dogEn = 1'b0;
    startHome(METHOD_DOG_FRONT, 1'b0, 70);
    waitEnd(-999, 1'b0);
    cycles(2);
    chk({alarm, revEnd, speedCmd_q}, {2'h3, SPD_STOP});
    tallyAndFinish();
  end
endmodule // tb
